// ### spm_top.sv
// serial master/slave port: registers, master rate divider, shifter, flags
// assumes register strobes on clk_i and serial pins from outside, synchronised here
`timescale 1ns/1ps

// Behaviour
// - enabled slave keeps select pin as input only
// - deselected slave floats output, ignores clocks
// - master select pin gated by fault enable
// - clock idles at polarity; reset polarity0 phase1
// - wired-or makes clock and data open-drain
// - enable low gives partial reset, keeps controls
// - partial reset sets empty, aborts, clears shifter
// - master bit picks role, reset selects master
// - receive enable gates receive-full onto request
// - transmit enable gates empty flag onto request
// - receive-full set on byte, status-then-data clears
// - error enable gates overflow and mode fault
// - overflow keeps old byte, drops new byte
// - mode fault on select misuse per role
// - mode fault cleared by status then control write
// - dropping fault enable keeps a set fault
// - master mode fault disables the port
// - empty set on hand-off, cleared by write
// - master rate divisor 2,8,32,128 by field
// - separate transmit and receive buffers, no reset
module spm_top
   import spm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic ss_n_i,
   output logic ss_gpio_o,
   output logic pullup_en_o
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic sck_prev_q;
   logic ss_prev_q;

   always_ff @(posedge clk_i) begin
      pin_s1_q <= {ss_n_i, miso_i, mosi_i, sck_i};
      pin_s2_q <= pin_s1_q;
      sck_prev_q <= pin_s2_q[0];
      ss_prev_q <= pin_s2_q[3];
   end

   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_n_s;
   assign sck_s = pin_s2_q[0];
   assign mosi_s = pin_s2_q[1];
   assign miso_s = pin_s2_q[2];
   assign ss_n_s = pin_s2_q[3];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic err_ie_q;
   logic mode_fault_enable_q;
   logic [1:0] rate_q;
   logic rxf_q;
   logic ovr_q;
   logic mode_fault_flag_q;
   logic txe_q;
   logic [7:0] tx_buf_q;
   logic [7:0] rx_buf_q;
   logic [7:0] rdata_q;
   logic rxf_arm_q;
   logic ovr_arm_q;
   logic mode_fault_flag_arm_q;

   logic en;
   logic master;
   logic cpol;
   logic cpha;
   logic wom;
   assign en = ctrl_q[SPM_CB_EN];
   assign master = ctrl_q[SPM_CB_MASTER];
   assign cpol = ctrl_q[SPM_CB_CPOL];
   assign cpha = ctrl_q[SPM_CB_CPHA];
   assign wom = ctrl_q[SPM_CB_WOM];

   logic wr_ctrl;
   logic wr_stat;
   logic wr_data;
   logic rd_stat;
   logic rd_data;
   assign wr_ctrl = wr_i && (addr_i == SPM_OFS_CONTROL);
   assign wr_stat = wr_i && (addr_i == SPM_OFS_STATUS);
   assign wr_data = wr_i && (addr_i == SPM_OFS_DATA);
   assign rd_stat = rd_i && (addr_i == SPM_OFS_STATUS);
   assign rd_data = rd_i && (addr_i == SPM_OFS_DATA);

   logic [7:0] status_val;
   always_comb begin
      status_val = 8'h00;
      status_val[SPM_SB_RXF] = rxf_q;
      status_val[SPM_SB_ERR_IE] = err_ie_q;
      status_val[SPM_SB_OVR] = ovr_q;
      status_val[SPM_SB_MODE_FAULT_FLAG] = mode_fault_flag_q;
      status_val[SPM_SB_TXE] = txe_q;
      status_val[SPM_SB_MODE_FAULT_ENABLE] = mode_fault_enable_q;
      status_val[SPM_SB_RATE_HI] = rate_q[1];
      status_val[SPM_SB_RATE_LO] = rate_q[0];
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            SPM_OFS_CONTROL: rdata_q <= ctrl_q;
            SPM_OFS_STATUS: rdata_q <= status_val;
            SPM_OFS_DATA: rdata_q <= rx_buf_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   // ----------------------------------------------------------------
   // mode fault detection
   // ----------------------------------------------------------------
   logic [3:0] edge_idx_q;
   logic busy;
   logic mode_fault;
   // master: select low at any time; slave: select rising mid-transfer
   assign mode_fault = en && mode_fault_enable_q && (master ? !ss_n_s
                     : (ss_n_s && !ss_prev_q && busy));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= SPM_CONTROL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_i & SPM_CONTROL_WMASK;
         end
         if (mode_fault && master) begin
            ctrl_q[SPM_CB_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_ie_q <= SPM_STATUS_CTL_RST[SPM_SB_ERR_IE];
         mode_fault_enable_q <= SPM_STATUS_CTL_RST[SPM_SB_MODE_FAULT_ENABLE];
         rate_q <= SPM_STATUS_CTL_RST[SPM_SB_RATE_HI:SPM_SB_RATE_LO];
      end else if (wr_stat) begin
         err_ie_q <= wdata_i[SPM_SB_ERR_IE];
         mode_fault_enable_q <= wdata_i[SPM_SB_MODE_FAULT_ENABLE];
         rate_q <= wdata_i[SPM_SB_RATE_HI:SPM_SB_RATE_LO];
      end
   end

   // ----------------------------------------------------------------
   // master rate divider
   // ----------------------------------------------------------------
   function automatic logic [7:0] rate_div(input logic [1:0] sel);
      case (sel)
         2'b00: rate_div = SPM_DIV_0;
         2'b01: rate_div = SPM_DIV_1;
         2'b10: rate_div = SPM_DIV_2;
         default: rate_div = SPM_DIV_3;
      endcase
   endfunction

   spm_state_t state_q;
   logic [7:0] div_cnt_q;
   logic tick;
   // one serial clock half period lasts the divisor, so sck = clk / (2 * divisor)
   assign tick = (state_q == SPM_ST_BUSY) && (div_cnt_q == rate_div(rate_q) - 8'h01);

   always_ff @(posedge clk_i) begin
      if (rst_i || !en || state_q != SPM_ST_BUSY || tick) begin
         div_cnt_q <= 8'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // shifter and edge sequencing
   // ----------------------------------------------------------------
   logic [7:0] shift_q;
   logic rx_bit_q;
   logic sck_q;
   logic slave_sel;
   logic slave_edge;
   logic edge_ev;
   logic sample_edge;
   logic din;
   logic done;
   logic load;
   logic cap_q;
   logic cap_last_q;
   logic [7:0] mrx_q;
   logic rx_done;

   assign slave_sel = en && !master && !ss_n_s;
   // deselected slave sees no clock edges at all
   assign slave_edge = slave_sel && (sck_s != sck_prev_q);
   assign edge_ev = master ? tick : slave_edge;
   assign busy = master ? (state_q == SPM_ST_BUSY) : (edge_idx_q != 4'h0);
   assign sample_edge = (edge_idx_q[0] == cpha);
   assign din = master ? miso_s : mosi_s;
   assign done = edge_ev && (edge_idx_q == SPM_LAST_EDGE);
   assign load = en && !txe_q && !busy && !edge_ev &&
                 (master ? (state_q == SPM_ST_IDLE) : 1'b1);

   always_ff @(posedge clk_i) begin
      if (rst_i || !en) begin
         state_q <= SPM_ST_IDLE;
      end else begin
         case (state_q)
            SPM_ST_IDLE: if (load && master) state_q <= SPM_ST_BUSY;
            SPM_ST_BUSY: if (done || !master) state_q <= SPM_ST_IDLE;
            default: state_q <= SPM_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en) begin
         edge_idx_q <= 4'h0;
         shift_q <= 8'h00;
         rx_bit_q <= 1'b0;
      end else if (!master && ss_n_s) begin
         edge_idx_q <= 4'h0;
         if (load) begin
            shift_q <= tx_buf_q;
         end
      end else if (load) begin
         shift_q <= tx_buf_q;
      end else if (edge_ev) begin
         edge_idx_q <= edge_idx_q + 4'h1;
         // the first edge in phase 1 leaves the data line alone, keeping the partner's hold time
         if (sample_edge) begin
            rx_bit_q <= din;
         end else if (!(cpha && edge_idx_q == 4'h0)) begin
            shift_q <= {shift_q[6:0], rx_bit_q};
         end
      end
   end

   // serial clock rests at the polarity level between bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_q <= 1'b0;
      end else if (state_q != SPM_ST_BUSY || !en) begin
         sck_q <= cpol;
      end else if (tick) begin
         sck_q <= !sck_q;
      end
   end

   // miso comes through the synchroniser, so the master takes it one cycle after its edge;
   // at the fastest rate the line would otherwise still show the previous bit
   always_ff @(posedge clk_i) begin
      if (rst_i || !en || !master) begin
         cap_q <= 1'b0;
         cap_last_q <= 1'b0;
      end else begin
         cap_q <= tick && sample_edge;
         cap_last_q <= done;
         if (cap_q) begin
            mrx_q <= {mrx_q[6:0], miso_s};
         end
      end
   end

   logic [7:0] rx_byte;
   assign rx_done = master ? cap_last_q : done;
   assign rx_byte = master ? (cap_q ? {mrx_q[6:0], miso_s} : mrx_q)
                  : (sample_edge ? {shift_q[6:0], din} : {shift_q[6:0], rx_bit_q});

   // ----------------------------------------------------------------
   // flags and buffers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (wr_data) begin
         tx_buf_q <= wdata_i;
      end
      if (rx_done && !rxf_q) begin
         rx_buf_q <= rx_byte;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txe_q <= 1'b1;
      end else if (!en || load) begin
         txe_q <= 1'b1;
      end else if (wr_data) begin
         txe_q <= 1'b0;
      end
   end

   // a status read that sees a flag arms its clear; the set always wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxf_q <= 1'b0;
         ovr_q <= 1'b0;
         rxf_arm_q <= 1'b0;
         ovr_arm_q <= 1'b0;
      end else begin
         if (rd_stat) begin
            rxf_arm_q <= rxf_q;
            ovr_arm_q <= ovr_q;
         end else if (rd_data) begin
            rxf_arm_q <= 1'b0;
            ovr_arm_q <= 1'b0;
         end
         if (rx_done && !rxf_q) begin
            rxf_q <= 1'b1;
         end else if (rd_data && rxf_arm_q) begin
            rxf_q <= 1'b0;
         end
         if (rx_done && rxf_q) begin
            ovr_q <= 1'b1;
         end else if (rd_data && ovr_arm_q) begin
            ovr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_fault_flag_q <= 1'b0;
         mode_fault_flag_arm_q <= 1'b0;
      end else begin
         if (rd_stat) begin
            mode_fault_flag_arm_q <= mode_fault_flag_q;
         end else if (wr_ctrl) begin
            mode_fault_flag_arm_q <= 1'b0;
         end
         // only setting depends on the enable, so clearing it leaves the flag alone
         if (mode_fault) begin
            mode_fault_flag_q <= 1'b1;
         end else if (wr_ctrl && mode_fault_flag_arm_q) begin
            mode_fault_flag_q <= 1'b0;
         end
      end
   end

   assign irq_o = (ctrl_q[SPM_CB_RX_IE] && rxf_q)
                || (ctrl_q[SPM_CB_TX_IE] && txe_q && en)
                || (err_ie_q && (ovr_q || mode_fault_flag_q));

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   logic drv_sck;
   logic drv_mosi;
   logic drv_miso;
   assign drv_sck = en && master;
   assign drv_mosi = en && master;
   assign drv_miso = slave_sel;

   // wired-or pins only pull low; the external pullup supplies the high level
   assign sck_o = sck_q;
   assign mosi_o = shift_q[7];
   assign miso_o = shift_q[7];
   assign sck_oe_o = drv_sck && (!wom || !sck_q);
   assign mosi_oe_o = drv_mosi && (!wom || !shift_q[7]);
   assign miso_oe_o = drv_miso && (!wom || !shift_q[7]);
   assign pullup_en_o = !wom;

   // an enabled slave never gives the select pin back; an enabled master does unless faults are watched; a disabled port always does
   assign ss_gpio_o = !en || (master && !mode_fault_enable_q);

endmodule // spm_top

// ### spm_pkg.sv
// package of constants for the serial master/slave port
// assumes a byte-wide register port and a single 200 MHz clock taken as the clock generator output
package spm_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] SPM_OFS_CONTROL = 16'h0010;
   localparam logic [15:0] SPM_OFS_STATUS = 16'h0011;
   localparam logic [15:0] SPM_OFS_DATA = 16'h0012;

   // ----------------------------------------------------------------
   // serial_control fields
   // ----------------------------------------------------------------
   localparam int SPM_CB_RX_IE = 7;
   localparam int SPM_CB_MASTER = 5;
   localparam int SPM_CB_CPOL = 4;
   localparam int SPM_CB_CPHA = 3;
   localparam int SPM_CB_WOM = 2;
   localparam int SPM_CB_EN = 1;
   localparam int SPM_CB_TX_IE = 0;
   localparam logic [7:0] SPM_CONTROL_RST = 8'h28;
   localparam logic [7:0] SPM_CONTROL_WMASK = 8'hBF;

   // ----------------------------------------------------------------
   // serial_status_control fields
   // ----------------------------------------------------------------
   localparam int SPM_SB_RXF = 7;
   localparam int SPM_SB_ERR_IE = 6;
   localparam int SPM_SB_OVR = 5;
   localparam int SPM_SB_MODE_FAULT_FLAG = 4;
   localparam int SPM_SB_TXE = 3;
   localparam int SPM_SB_MODE_FAULT_ENABLE = 2;
   localparam int SPM_SB_RATE_HI = 1;
   localparam int SPM_SB_RATE_LO = 0;
   localparam logic [7:0] SPM_STATUS_CTL_RST = 8'h00;

   // ----------------------------------------------------------------
   // master rate divisors and transfer length
   // ----------------------------------------------------------------
   localparam logic [7:0] SPM_DIV_0 = 8'h02;
   localparam logic [7:0] SPM_DIV_1 = 8'h08;
   localparam logic [7:0] SPM_DIV_2 = 8'h20;
   localparam logic [7:0] SPM_DIV_3 = 8'h80;
   localparam logic [3:0] SPM_LAST_EDGE = 4'hF;

   typedef enum logic [1:0] {
      SPM_ST_IDLE = 2'b01,
      SPM_ST_BUSY = 2'b10
   } spm_state_t;

endpackage

// ### spm_sva.sv
// checker for the serial port: timing relations seen at the top ports
// assumes it is bound onto spm_top and sees nothing but its ports
`timescale 1ns/1ps
module spm_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic mosi_o,
   input wire logic mosi_oe_o,
   input wire logic miso_oe_o,
   input wire logic ss_n_i,
   input wire logic ss_gpio_o,
   input wire logic pullup_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_rdata_quiet; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside its cycle");
   property p_reset_idle;
      $past(rst_i) |-> !irq_o && !sck_oe_o && !mosi_oe_o && !miso_oe_o && !sck_o
         && ss_gpio_o && pullup_en_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("port not idle after reset");
   // the select synchroniser needs a few cycles, hence the run of four
   property p_float; ss_n_i [*4] |-> !miso_oe_o; endproperty
   a_float: assert property (p_float) else $error("deselected slave drives output");
   property p_ss_input; miso_oe_o |-> !ss_gpio_o; endproperty
   a_ss_input: assert property (p_ss_input) else $error("slave released select pin");
   property p_one_role; miso_oe_o |-> !sck_oe_o && !mosi_oe_o; endproperty
   a_one_role: assert property (p_one_role) else $error("master and slave drive at once");
   property p_open_drain;
      !pullup_en_o |-> (!sck_oe_o || !sck_o) && (!mosi_oe_o || !mosi_o);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("wired-or pin driven high");
   property p_half_period;
      $changed(sck_o) && sck_oe_o |=> $stable(sck_o) || !sck_oe_o;
   endproperty
   a_half_period: assert property (p_half_period) else $error("clock half period too short");
   property p_fault_stop; sck_oe_o && !ss_gpio_o && !ss_n_i |-> ##[0:6] !sck_oe_o; endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("master kept driving on fault");
   c_read: cover property (rd_i);
   c_clock: cover property ($rose(sck_o));
   c_fault: cover property (sck_oe_o && !ss_n_i);
   c_slave: cover property (miso_oe_o);
endmodule // spm_sva

bind spm_top spm_sva u_sva (.clk_i, .rst_i, .rd_i, .rdata_o, .irq_o, .sck_o, .sck_oe_o,
   .mosi_o, .mosi_oe_o, .miso_oe_o, .ss_n_i, .ss_gpio_o, .pullup_en_o);

// ### spm_far_slave.sv
// far-side slave for master tests: clock idles low, shift on leading edge
// assumes the bench resolves clock and data lines; en_i low aborts a byte
`timescale 1ns/1ps
module spm_far_slave (
   input wire logic en_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic [7:0] tx_i,
   output logic miso_o,
   output logic [7:0] rx_o
);
   logic [7:0] sh_q = 8'h00;
   logic [7:0] in_q = 8'h00;
   int n = 0;
   initial miso_o = 1'b0;
   initial rx_o = 8'h00;
   always @(posedge sck_i) begin
      if (n == 0) begin
         sh_q = tx_i;
      end
      miso_o <= sh_q[7]; // msb first on the leading edge
      sh_q = {sh_q[6:0], 1'b0};
   end
   always @(negedge sck_i) begin
      in_q = {in_q[6:0], mosi_i}; // sampled on the trailing edge
      n = n + 1;
      if (n == 8) begin
         n = 0;
         rx_o = in_q;
         miso_o <= ~miso_o; // released line must not look like valid data
      end
   end
   always @(negedge en_i) n = 0;
endmodule // spm_far_slave

// ### testbench.sv
// self-checking bench for the serial port through its register port
// assumes spm_top, its package and the far-side slave model
`timescale 1ns/1ps
module testbench import spm_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sck_i = 1'b0;
   logic mosi_i = 1'b0;
   logic ss_n_i = 1'b1;
   logic [7:0] far_tx = 8'h3C;
   logic [7:0] pat = 8'h96;
   logic [7:0] divs [4] = '{SPM_DIV_0, SPM_DIV_1, SPM_DIV_2, SPM_DIV_3};
   logic [7:0] rdata_o, far_rx, s;
   logic irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, ss_gpio_o;
   logic pullup_en_o, far_miso;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int n;
   always #2.5 clk_i = ~clk_i;
   spm_top dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .sck_i,
      .sck_o, .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i(far_miso), .miso_o,
      .miso_oe_o, .ss_n_i, .ss_gpio_o, .pullup_en_o);
   spm_far_slave far (.en_i(sck_oe_o), .sck_i(sck_oe_o & sck_o),
      .mosi_i(mosi_oe_o ? mosi_o : 1'b1), .tx_i(far_tx), .miso_o(far_miso), .rx_o(far_rx));
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic wait_rx(output logic [7:0] st);
      st = 8'h00;
      for (int i = 0; i < 1000 && !st[7]; i++) rd(SPM_OFS_STATUS, st);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         $display("Error at %0t: timeout", $time);
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(SPM_OFS_CONTROL, 8'h28);
      rchk(SPM_OFS_STATUS, 8'h08);
      rchk(16'h0013, 8'h00);
      chk({6'h00, ss_gpio_o, pullup_en_o}, 8'h03);
      wr(SPM_OFS_CONTROL, 8'h2A);
      for (int r = 0; r < 4; r++) begin
         wr(SPM_OFS_STATUS, 8'(r));
         wr(SPM_OFS_DATA, 8'hA5);
         n = 0;
         for (int i = 0; i < 400 && sck_o !== 1'b1; i++) @(posedge clk_i) #1;
         while (sck_o === 1'b1 && n < 400) @(posedge clk_i) #1 n++;
         @(posedge clk_i);
         chk(8'(n), divs[r]);
         wait_rx(s);
         chk(s, 8'h88 | 8'(r));
         chk(far_rx, 8'hA5);
         rchk(SPM_OFS_DATA, 8'h3C);
      end
      wr(SPM_OFS_STATUS, 8'h00);
      wr(SPM_OFS_DATA, 8'h11);
      wait_rx(s);
      far_tx = 8'hC3;
      wr(SPM_OFS_DATA, 8'h22);
      repeat (80) @(posedge clk_i);
      rchk(SPM_OFS_STATUS, 8'hA8);
      wr(SPM_OFS_CONTROL, 8'hAA);
      chk({7'h00, irq_o}, 8'h01);
      rchk(SPM_OFS_DATA, 8'h3C);
      rchk(SPM_OFS_STATUS, 8'h08);
      chk({7'h00, irq_o}, 8'h00);
      wr(SPM_OFS_CONTROL, 8'h2B);
      chk({7'h00, irq_o}, 8'h01);
      wr(SPM_OFS_CONTROL, 8'h2A);
      wr(SPM_OFS_STATUS, 8'h03);
      wr(SPM_OFS_DATA, 8'h5A);
      repeat (300) @(posedge clk_i);
      wr(SPM_OFS_CONTROL, 8'h28);
      rchk(SPM_OFS_STATUS, 8'h0B);
      chk({6'h00, sck_oe_o, sck_o}, 8'h00);
      rchk(SPM_OFS_CONTROL, 8'h28);
      wr(SPM_OFS_CONTROL, 8'h2A);
      wr(SPM_OFS_STATUS, 8'h04);
      chk({7'h00, ss_gpio_o}, 8'h00);
      ss_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rchk(SPM_OFS_STATUS, 8'h1C);
      rchk(SPM_OFS_CONTROL, 8'h28);
      ss_n_i <= 1'b1;
      wr(SPM_OFS_STATUS, 8'h40);
      rchk(SPM_OFS_STATUS, 8'h58);
      chk({7'h00, irq_o}, 8'h01);
      wr(SPM_OFS_CONTROL, 8'h2A);
      rchk(SPM_OFS_STATUS, 8'h48);
      chk({7'h00, ss_gpio_o}, 8'h01);
      wr(SPM_OFS_CONTROL, 8'h3A);
      rchk(SPM_OFS_CONTROL, 8'h3A);
      chk({7'h00, sck_o}, 8'h01);
      wr(SPM_OFS_STATUS, 8'h00);
      wr(SPM_OFS_CONTROL, 8'h2E);
      chk({7'h00, pullup_en_o}, 8'h00);
      wr(SPM_OFS_CONTROL, 8'h0A);
      chk({6'h00, ss_gpio_o, pullup_en_o}, 8'h01);
      ss_n_i <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sck_i <= 1'b1;
         mosi_i <= pat[i];
         repeat (8) @(posedge clk_i);
         sck_i <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
      chk({7'h00, miso_oe_o}, 8'h01);
      ss_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({7'h00, miso_oe_o}, 8'h00);
      rchk(SPM_OFS_STATUS, 8'h88);
      rchk(SPM_OFS_DATA, 8'h96);
      for (int i = 0; i < 16; i++) begin
         sck_i <= ~sck_i;
         repeat (4) @(posedge clk_i);
      end
      rchk(SPM_OFS_STATUS, 8'h08);
      // slave with phase 0 and polarity 1: clock idles high, select framed per byte
      wr(SPM_OFS_CONTROL, 8'h12);
      sck_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      ss_n_i <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_i <= !pat[i];
         repeat (4) @(posedge clk_i);
         sck_i <= 1'b0;
         repeat (8) @(posedge clk_i);
         sck_i <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
      ss_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rchk(SPM_OFS_STATUS, 8'h88);
      rchk(SPM_OFS_DATA, 8'h69);
      give_verdict();
   end
endmodule // testbench
